// File: phy_basic_control_status_regs.v
// Management register bank of a 10/100 transceiver, reached over the
// serial management pins; the management clock and data pin are sampled
// by the core clock, which must run well above the management clock.
//
// Contract
// - Writing one to the soft reset bit resets the device and the bit self-clears.
// - The loopback bit selects loopback when set and resets to zero.
// - The speed bit picks 100 Mbps when one and 10 Mbps when zero, ignored while negotiating.
// - Negotiation enable starts negotiation and its outcome overrides speed and duplex.
// - At reset speed, negotiation, isolate and inverted duplex load from straps.
// - The power-down bit selects power-down when set and resets to zero.
// - The isolate bit detaches the device from the MAC interface and the line transmitter.
// - Writing one to restart negotiation restarts it and the bit self-clears.
// - The duplex bit selects full duplex when one, half duplex when zero.
// - The collision test bit enables the collision test and resets to zero.
// - The transmitter disable bit at position zero turns the transmitter off and resets to zero.
// - Basic status bit 15 is read-only zero.
// - Basic status bit 14 is read-only one.
// - Only addresses 0-8, 14h, 15h, 1Bh, 1Eh, 1Fh exist; the rest are reserved.
// - Power-down stops all functions except the management interface.
//
// Timing notes
// Both management pins pass two flops, the clock also an edge detector, so every
// bit is seen about three core cycles after the station's clock edge.
// The core clock must therefore run at least eight times faster than
// the management clock, or read data would miss the station's sample.
// A read answer is driven from the falling edge that ends the last
// address bit: one turnaround zero, then sixteen data bits MSB first.
// Writes land at the rising edge of the last data bit; only address
// zero holds writable state, the other implemented addresses ignore writes.
// Strap pins are also pins, so they pass two flops before use; the
// flops run during reset so the levels are settled at release.
`timescale 1ns/10ps
`default_nettype none
`include "phy_mgmt_regs.vh"

module phy_basic_control_status_regs #(
  parameter [4:0] PHY_ADDRESS = 5'h01,
  parameter [15:0] ID_HIGH    = 16'h1234, // Arbitrary value
  parameter [15:0] ID_LOW     = 16'h5678  // Arbitrary value
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        mgmt_clock,
  input  wire        mgmt_data_in,
  output reg         mgmt_data_out,
  output reg         mgmt_data_oe,
  input  wire        speed_strap,
  input  wire        negotiation_enable_strap,
  input  wire        isolate_strap,
  input  wire        duplex_strap,
  input  wire        neg_done,
  input  wire        neg_speed_100,
  input  wire        neg_full_duplex,
  output reg         core_reset,
  output reg         loopback_mode,
  output reg         speed_100,
  output reg         full_duplex,
  output reg         neg_enable,
  output reg         neg_restart,
  output reg         power_down,
  output reg         isolate,
  output reg         col_test,
  output reg         tx_disable
);

  // Frame states
  // IDLE  : waits for the zero that opens the start field
  // HEAD  : collects start, op code, device and register address
  // TURN  : judges the head and picks a path; a read for this device waits here for the next fall
  // WTURN : skips the two turnaround bits of a write or foreign frame
  // DATA  : shifts sixteen bits in, or drives sixteen bits out
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_HEAD  = 3'h1;
  localparam [2:0] ST_TURN  = 3'h2;
  localparam [2:0] ST_DATA  = 3'h3;
  localparam [2:0] ST_WTURN = 3'h4;

  // Two-stage synchronisers for the management pins
  reg  [1:0]  mdc_sync_q;
  reg  [1:0]  mdi_sync_q;
  reg         mdc_last_q;
  reg  [2:0]  state_q;
  reg  [5:0]  count_q;
  reg  [13:0] head_q;
  reg  [15:0] shift_q;
  reg  [15:0] ctrl_q;
  reg  [7:0]  rst_cnt_q;
  reg         strap_load_q;
  reg  [3:0]  strap_meta_q;
  reg  [3:0]  strap_q;
  reg         drive_q;
  reg  [15:0] read_data;
  reg         addr_known;
  wire        mdc_rise;
  wire        mdc_fall;
  wire        mdi;
  wire [1:0]  frame_op;
  wire [4:0]  frame_phy;
  wire [4:0]  frame_reg;
  wire        frame_mine;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_sync_q <= 2'h0;
      mdi_sync_q <= 2'h3;
      mdc_last_q <= 1'b0;
    end else begin
      mdc_sync_q <= {mdc_sync_q[0], mgmt_clock};
      mdi_sync_q <= {mdi_sync_q[0], mgmt_data_in};
      mdc_last_q <= mdc_sync_q[1];
    end
  end

  // Strap levels: speed, negotiation, isolate, duplex.
  // No reset here, so the two stages fill while reset is held and
  // the first edge after release already sees the settled levels.
  always @(posedge clock) begin
    strap_meta_q <= {speed_strap, negotiation_enable_strap, isolate_strap, duplex_strap};
    strap_q      <= strap_meta_q;
  end

  // Edges of the synchronised management clock; idle level is low
  assign mdc_rise   = mdc_sync_q[1] & ~mdc_last_q;
  assign mdc_fall   = ~mdc_sync_q[1] & mdc_last_q;
  assign mdi        = mdi_sync_q[1];
  // Head holds start, op, phy address, register address
  assign frame_op   = head_q[11:10];
  assign frame_phy  = head_q[9:5];
  assign frame_reg  = head_q[4:0];
  assign frame_mine = (frame_phy == PHY_ADDRESS);

  // Address decode; reserved addresses read zero and ignore writes.
  // Implemented registers other than control, status and the two
  // identifier words have no fields here, so they read zero as well.
  // The known flag gates writes so an unmapped address never lands.
  always @* begin
    addr_known = 1'b1;
    read_data  = 16'h0000;
    case (frame_reg)
      `REG_BASIC_CONTROL:     read_data = ctrl_q;
      `REG_BASIC_STATUS:      read_data = `BASIC_STATUS_VALUE
                                          | ({15'h0000, neg_done} << `BS_NEG_DONE);
      `REG_ID_HIGH:           read_data = ID_HIGH;
      `REG_ID_LOW:            read_data = ID_LOW;
      `REG_NEG_ADVERT,
      `REG_PARTNER_ABILITY,
      `REG_NEG_EXPANSION,
      `REG_LOCAL_NEXT_PAGE,
      `REG_PARTNER_NEXT_PAGE,
      `REG_MII_CONTROL,
      `REG_RX_ERR_COUNT,
      `REG_INT_CTRL_STATUS,
      `REG_XCVR_CONTROL_ONE,
      `REG_XCVR_CONTROL_TWO:  read_data = 16'h0000;
      default:                addr_known = 1'b0;
    endcase
  end

  // Frame engine; samples on rising management clock, drives after falling.
  // Kept alive in power-down so the bit can be cleared again.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      count_q <= 6'h00;
      head_q  <= 14'h0000;
      shift_q <= 16'h0000;
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          drive_q <= 1'b0;
          // Preamble ones then a zero begins the start field
          if (mdc_rise && !mdi) begin
            head_q  <= 14'h0000;
            count_q <= 6'h00;
            state_q <= ST_HEAD;
          end
        end
        ST_HEAD: if (mdc_rise) begin
          head_q  <= {head_q[12:0], mdi};
          count_q <= count_q + 6'h01;
          // Thirteen more bits after the first start bit
          if (count_q == `HEAD_LAST_BIT) begin
            count_q <= 6'h00;
            state_q <= ST_TURN;
          end
        end
        ST_TURN: begin
          // Start must be 01, else drop the frame
          if (head_q[12] != 1'b1) begin
            state_q <= ST_IDLE;
          end else if (frame_op == `MDIO_OP_READ && frame_mine) begin
            if (mdc_fall) begin
              shift_q <= read_data;
              state_q <= ST_DATA;
              count_q <= 6'h00;
              drive_q <= 1'b1; // Turnaround zero bit driven first
            end
          end else if (frame_op == `MDIO_OP_WRITE) begin
            state_q <= ST_WTURN;
          end else begin
            state_q <= ST_WTURN;
          end
        end
        ST_WTURN: if (mdc_rise) begin
          count_q <= count_q + 6'h01;
          // Two turnaround bits, then data
          if (count_q == `WTURN_LAST_BIT) begin
            count_q <= 6'h00;
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          // Read: the first fall after turnaround only exposes bit 15,
          // later falls move the next bit up; the pin is released at
          // the seventeenth fall so the station regains the line.
          if (drive_q && mdc_fall && count_q != 6'h00) begin
            shift_q <= {shift_q[14:0], 1'b0};
          end
          if (mdc_fall && drive_q) begin
            count_q <= count_q + 6'h01;
            if (count_q == `READ_LAST_FALL) begin
              drive_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          // Write or foreign frame: sample on each rise, MSB first
          if (mdc_rise && !drive_q) begin
            shift_q <= {shift_q[14:0], mdi};
            count_q <= count_q + 6'h01;
            if (count_q == `DATA_LAST_BIT) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Write strobe at the rise of the last data bit. The last bit is
  // taken straight from the pin stage so the word is whole this cycle;
  // frames for another device or an unmapped address never strobe.
  wire write_done = (state_q == ST_DATA) && !drive_q && mdc_rise
                    && (count_q == `DATA_LAST_BIT) && addr_known
                    && frame_mine && (frame_op == `MDIO_OP_WRITE);
  wire [15:0] wdata = {shift_q[14:0], mdi};

  // Control register; strap values caught one cycle after reset release.
  // A soft reset holds the core for a fixed count, then reloads the
  // straps as a power-up would; the bit itself never reads back one.
  // Restart is a one-cycle pulse: the bit is cleared on the next cycle
  // unless a new write sets it again, in which case the write wins.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q       <= 16'h0000;
      strap_load_q <= 1'b1;
      rst_cnt_q    <= 8'h00;
    end else if (strap_load_q || rst_cnt_q == 8'h01) begin
      strap_load_q            <= 1'b0;
      rst_cnt_q               <= 8'h00;
      ctrl_q                  <= 16'h0000;
      ctrl_q[`BC_SPEED]       <= strap_q[3];
      ctrl_q[`BC_NEG_ENABLE]  <= strap_q[2];
      ctrl_q[`BC_ISOLATE]     <= strap_q[1];
      ctrl_q[`BC_DUPLEX]      <= ~strap_q[0];
    end else begin
      if (rst_cnt_q != 8'h00) begin
        rst_cnt_q <= rst_cnt_q - 8'h01;
      end
      // Restart pulse lasts one cycle then clears
      ctrl_q[`BC_NEG_RESTART] <= 1'b0;
      if (write_done && frame_reg == `REG_BASIC_CONTROL) begin
        ctrl_q <= wdata & `BC_WRITE_MASK;
        ctrl_q[`BC_SOFT_RESET] <= 1'b0;
        if (wdata[`BC_SOFT_RESET]) begin
          rst_cnt_q <= `SOFT_RESET_CYCLES;
        end
      end
    end
  end

  // Registered outputs toward the core and the data pin.
  // Every output comes from a flop so the core sees clean levels.
  // Power-down is carried out by holding the core in reset; the frame
  // engine and this register stay clocked so the bit can be cleared.
  // Isolate also forces the transmitter off, which detaches the line.
  // The pin value is masked during turnaround so it starts low.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_reset    <= 1'b1;
      loopback_mode <= 1'b0;
      speed_100     <= 1'b0;
      full_duplex   <= 1'b0;
      neg_enable    <= 1'b0;
      neg_restart   <= 1'b0;
      power_down    <= 1'b0;
      isolate       <= 1'b0;
      col_test      <= 1'b0;
      tx_disable    <= 1'b0;
      mgmt_data_out <= 1'b0;
      mgmt_data_oe  <= 1'b0;
    end else begin
      core_reset    <= (rst_cnt_q != 8'h00) | ctrl_q[`BC_POWER_DOWN];
      loopback_mode <= ctrl_q[`BC_LOOPBACK];
      // Negotiated result overrides manual speed and duplex
      speed_100     <= ctrl_q[`BC_NEG_ENABLE] ? neg_speed_100 : ctrl_q[`BC_SPEED];
      full_duplex   <= ctrl_q[`BC_NEG_ENABLE] ? neg_full_duplex
                                               : ctrl_q[`BC_DUPLEX];
      neg_enable    <= ctrl_q[`BC_NEG_ENABLE];
      neg_restart   <= ctrl_q[`BC_NEG_RESTART];
      power_down    <= ctrl_q[`BC_POWER_DOWN];
      isolate       <= ctrl_q[`BC_ISOLATE];
      col_test      <= ctrl_q[`BC_COL_TEST];
      tx_disable    <= ctrl_q[`BC_TX_DISABLE] | ctrl_q[`BC_ISOLATE];
      mgmt_data_out <= shift_q[15] & (count_q != 6'h00);
      mgmt_data_oe  <= drive_q;
    end
  end

endmodule // phy_basic_control_status_regs
`default_nettype wire

// File: phy_mgmt_regs.vh
// Register map, field positions and reset values of the management bank.
// Included by the management register bank; definitions only.
`ifndef PHY_MGMT_REGS_VH
`define PHY_MGMT_REGS_VH

// Register addresses on the 5-bit management space
`define REG_BASIC_CONTROL      5'h00
`define REG_BASIC_STATUS       5'h01
`define REG_ID_HIGH            5'h02
`define REG_ID_LOW             5'h03
`define REG_NEG_ADVERT         5'h04
`define REG_PARTNER_ABILITY    5'h05
`define REG_NEG_EXPANSION      5'h06
`define REG_LOCAL_NEXT_PAGE    5'h07
`define REG_PARTNER_NEXT_PAGE  5'h08
`define REG_MII_CONTROL        5'h14
`define REG_RX_ERR_COUNT       5'h15
`define REG_INT_CTRL_STATUS    5'h1B
`define REG_XCVR_CONTROL_ONE   5'h1E
`define REG_XCVR_CONTROL_TWO   5'h1F

// Basic control bit positions
`define BC_SOFT_RESET          15
`define BC_LOOPBACK            14
`define BC_SPEED               13
`define BC_NEG_ENABLE          12
`define BC_POWER_DOWN          11
`define BC_ISOLATE             10
`define BC_NEG_RESTART         9
`define BC_DUPLEX              8
`define BC_COL_TEST            7
`define BC_TX_DISABLE          0

// Basic status fixed value: four-pair mode absent, capability bits set
`define BASIC_STATUS_VALUE     16'h7849

// Frame field codes
`define MDIO_OP_WRITE          2'h1
`define MDIO_OP_READ           2'h2
`define MDIO_TA_WRITE          2'h2

// Soft reset hold time in cycles
`define SOFT_RESET_CYCLES      8'h10

// Writable bits of basic control: 15..7 and 0; 6..1 stay zero
`define BC_WRITE_MASK          16'hFF81

// Basic status bit that mirrors negotiation complete
`define BS_NEG_DONE            5

// Frame bit counters: last index of each field
`define HEAD_LAST_BIT          6'h0C
`define WTURN_LAST_BIT         6'h01
`define DATA_LAST_BIT          6'h0F
`define READ_LAST_FALL         6'h10

`endif

// File: phy_regs_asserts.sv
// Output relations of the management register bank.
// Bound to the bank; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module phy_regs_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mgmt_clock,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe,
  input wire logic neg_speed_100,
  input wire logic neg_full_duplex,
  input wire logic core_reset,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic neg_enable,
  input wire logic neg_restart,
  input wire logic power_down,
  input wire logic isolate,
  input wire logic tx_disable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Mode outputs tied to their causes
  a_iso_tx_off: assert property (isolate |-> tx_disable) else $error("tx on while isolated");
  a_restart_pulse: assert property (neg_restart |=> !neg_restart) else $error("restart held");
  a_neg_speed: assert property ((neg_enable && $stable(neg_speed_100))[*3] |->
    speed_100 == neg_speed_100) else $error("speed not negotiated");
  a_neg_duplex: assert property ((neg_enable && $stable(neg_full_duplex))[*3] |->
    full_duplex == neg_full_duplex) else $error("duplex not negotiated");
  a_pd_core_off: assert property (power_down |-> core_reset) else $error("core alive");
  a_soft_rst_len: assert property ($rose(core_reset) && !power_down |-> core_reset[*8])
    else $error("soft reset short");
  // Read answer framing: starts low, released in clock low phase
  a_ta_low: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_out) else $error("ta high");
  // The drop lands a few core cycles after the falling edge seen on
  // the pin, so the clock is checked low two cycles back
  a_oe_release: assert property ($fell(mgmt_data_oe) |-> !$past(mgmt_clock, 2))
    else $error("late drop");
endmodule // phy_regs_asserts
bind phy_basic_control_status_regs phy_regs_asserts chk (.clock(clock), .sys_rst(sys_rst),
  .mgmt_clock(mgmt_clock), .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe),
  .neg_speed_100(neg_speed_100), .neg_full_duplex(neg_full_duplex), .core_reset(core_reset),
  .speed_100(speed_100), .full_duplex(full_duplex), .neg_enable(neg_enable),
  .neg_restart(neg_restart), .power_down(power_down), .isolate(isolate),
  .tx_disable(tx_disable));
`default_nettype wire

// File: station_model.sv
// Station manager model driving the management clock and data pin.
// Runs off the core clock; the bench resolves the shared data line.
`timescale 1ns/10ps
`default_nettype none
module station_model (
  input  wire logic clock,
  input  wire logic mdio_level,
  output var  logic mgmt_clock,
  output var  logic drive_d,
  output var  logic drive_oe
);
  initial begin
    mgmt_clock = 1'b0;
    drive_d = 1'b1;
    drive_oe = 1'b0;
  end
  // One 80 ns bit; data moves with the falling edge
  task automatic bit_cyc(input logic b, output logic s);
    drive_d <= b;
    repeat (4) @(posedge clock);
    mgmt_clock <= 1'b1;
    repeat (4) @(posedge clock);
    s = mdio_level; // Late in the bit, clear of the device's update
    mgmt_clock <= 1'b0;
  endtask
  // Whole frame; clock stands still between frames
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [63:0] f;
    logic        s;
    f = {32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra, 2'b10, wd};
    q = 16'h0000;
    @(posedge clock);
    drive_oe <= 1'b1;
    for (int i = 63; i >= 0; i--) begin
      if (rd && i < 18) drive_oe <= 1'b0; // Hand the line to the device
      bit_cyc(f[i], s);
      if (rd && i >= 1 && i <= 16) q = {q[14:0], s};
    end
    drive_oe <= 1'b0;
    bit_cyc(1'b1, s); // Idle one between frames
  endtask
endmodule // station_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the management register bank.
// Straps fixed: speed 1, negotiation 0, isolate 1, duplex 0.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock, sys_rst, mdio_level, neg_done, neg_speed_100, neg_full_duplex, mc, st_d, st_oe;
  logic out_d, out_oe, core_reset, loopback_mode, speed_100, full_duplex, neg_enable;
  logic neg_restart, power_down, isolate, col_test, tx_disable;
  logic [15:0] rd_q, outs;
  int error_cnt = 0, n_tests = 0, cyc_cnt = 0, pulses = 0;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Pull-up on the data line when nobody drives
  assign mdio_level = out_oe ? out_d : (st_oe ? st_d : 1'b1);
  assign outs = {8'h00, loopback_mode, speed_100, full_duplex, neg_enable, power_down, isolate,
                 col_test, tx_disable};
  phy_basic_control_status_regs uut (.clock(clock), .sys_rst(sys_rst), .mgmt_clock(mc),
    .mgmt_data_in(mdio_level), .mgmt_data_out(out_d), .mgmt_data_oe(out_oe),
    .speed_strap(1'b1), .negotiation_enable_strap(1'b0), .isolate_strap(1'b1),
    .duplex_strap(1'b0), .neg_done(neg_done), .neg_speed_100(neg_speed_100),
    .neg_full_duplex(neg_full_duplex), .core_reset(core_reset), .loopback_mode(loopback_mode),
    .speed_100(speed_100), .full_duplex(full_duplex), .neg_enable(neg_enable),
    .neg_restart(neg_restart), .power_down(power_down), .isolate(isolate), .col_test(col_test),
    .tx_disable(tx_disable));
  station_model stn (.clock(clock), .mdio_level(mdio_level), .mgmt_clock(mc), .drive_d(st_d),
    .drive_oe(st_oe));
  // Restart pulse count and hang guard
  always @(posedge clock) begin
    cyc_cnt++;
    if (neg_restart === 1'b1) pulses++;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    stn.frame(1'b1, a, 16'h0000, rd_q);
    chk(rd_q, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    stn.frame(1'b0, a, v, rd_q);
  endtask
  task automatic t_reset;
    rd(5'h00, 16'h2500);
    chk(outs, 16'h0065);
    rd(5'h01, 16'h7849);
  endtask
  task automatic t_modes;
    wr(5'h00, 16'h41FF);
    rd(5'h00, 16'h4181);
    chk(outs, 16'h00A3);
  endtask
  task automatic t_neg;
    @(posedge clock);
    neg_speed_100 <= 1'b1;
    neg_full_duplex <= 1'b1;
    neg_done <= 1'b1;
    wr(5'h00, 16'h1200);
    rd(5'h00, 16'h1000);
    chk(pulses, 16'h0001);
    chk(outs, 16'h0070);
    rd(5'h01, 16'h7869);
  endtask
  task automatic t_power;
    wr(5'h00, 16'h0800);
    chk(core_reset, 1'b1);
    rd(5'h00, 16'h0800);
    wr(5'h00, 16'h0000);
    chk(outs, 16'h0000);
  endtask
  task automatic t_soft;
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h2500);
  endtask
  task automatic t_reserved;
    logic [4:0] adr [6] = '{5'h09, 5'h13, 5'h16, 5'h1A, 5'h1C, 5'h1D};
    foreach (adr[k]) begin
      wr(adr[k], 16'hFFFF);
      rd(adr[k], 16'h0000);
    end
    rd(5'h00, 16'h2500);
  endtask
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    neg_done = 1'b0;
    neg_speed_100 = 1'b0;
    neg_full_duplex = 1'b0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_modes();
    t_neg();
    t_power();
    t_soft();
    t_reserved();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
